// ### inc/dmac_pkg.sv
package dmac_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [31:0] OFF_FLAGS = 32'h00;
  localparam logic [31:0] OFF_FLAG_CLR = 32'h04;
  localparam logic [31:0] OFF_SW_TRIG = 32'h08;
  localparam logic [31:0] OFF_CH_BASE = 32'h10;
  localparam int CH_SHIFT = 4;
  localparam logic [3:0] CH_CFG = 4'h0;
  localparam logic [3:0] CH_CNT = 4'h4;
  localparam logic [3:0] CH_PADDR = 4'h8;
  localparam logic [3:0] CH_MADDR = 4'hC;
  // ==========================================================
  // Channel configuration fields
  localparam int CFG_EN = 0;
  localparam int CFG_HALF_IE = 1;
  localparam int CFG_ERR_IE = 3;
  localparam int CFG_DIR = 4;
  localparam int CFG_CIRC = 6;
  localparam int CFG_PSTEP = 7;
  localparam int CFG_MSTEP = 8;
  localparam int CFG_PW = 9;
  localparam int CFG_MW = 11;
  localparam int CFG_PRI = 13;
  localparam int CFG_SEL = 15;
  localparam int CFG_W = 19;
  localparam int CNT_W = 16;
  localparam int PRI_W = 2;
  localparam int SEL_W = 4;
  localparam int N_SRC = 16;
  // ==========================================================
  // Event flags, three per channel
  localparam int FLG_HALF = 0;
  localparam int FLG_DONE = 1;
  localparam int FLG_ERR = 2;
  localparam int FLG_N = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DIR_P2M, DIR_M2P, DIR_M2M} dmac_dir_e;
  typedef enum logic [1:0] {XF_IDLE, XF_READ, XF_WRITE} dmac_xfer_e;
  // Width code 3 is treated as a word
  function automatic logic [31:0] dmac_width_mask(input logic [1:0] w);
    dmac_width_mask = (w == 2'h0) ? 32'h000000FF : (w == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction : dmac_width_mask
  function automatic logic [31:0] dmac_step(input logic [1:0] w);
    dmac_step = (w == 2'h0) ? 32'h1 : (w == 2'h1) ? 32'h2 : 32'h4;
  endfunction : dmac_step
endpackage : dmac_pkg

// ### inc/dmac_stream_if.sv
`timescale 1ns/1ns
interface dmac_stream_if #(
  parameter int W = 32
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface : dmac_stream_if

// ### design/dmac_fifo.sv
`timescale 1ns/1ns
module dmac_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input logic aclk,
  input logic aresetn,
  dmac_stream_if.store q
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("dmac_fifo: DEPTH must be a power of two, at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] rd;
    logic [AW:0] wr;
  } dmac_fifo_s;
  dmac_fifo_s s;
  dmac_fifo_s next_s;
  // Extra pointer bit tells full from empty
  assign q.in_ready = (s.wr[AW] == s.rd[AW]) || (s.wr[AW-1:0] != s.rd[AW-1:0]);
  assign q.out_valid = s.wr != s.rd;
  assign q.out_data = s.mem[s.rd[AW-1:0]];
  always_comb begin
    next_s = s;
    if (q.in_valid && q.in_ready) begin
      next_s.mem[s.wr[AW-1:0]] = q.in_data;
      next_s.wr = s.wr + 1'b1;
    end
    if (q.out_valid && q.out_ready) begin
      next_s.rd = s.rd + 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : dmac_fifo

// ### design/dmac_arbiter.sv
`timescale 1ns/1ns
module dmac_arbiter
  import dmac_pkg::*;
#(
  parameter int NUM_CH = 7,
  parameter int CH_W = 3
) (
  input logic [NUM_CH-1:0] pending,
  input logic [NUM_CH-1:0][PRI_W-1:0] prio,
  output logic grant_valid,
  output logic [CH_W-1:0] grant_idx
);
  logic [PRI_W-1:0] best;
  // Scan downward so an equal priority lets the lower channel take over
  always_comb begin
    grant_valid = 1'b0;
    grant_idx = '0;
    best = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending[i] && (!grant_valid || prio[i] >= best)) begin // [RL7] [RL16]
        grant_valid = 1'b1;
        grant_idx = CH_W'(i);
        best = prio[i];
      end
    end
  end
endmodule : dmac_arbiter

// ### design/dmac_top.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// [RL1] Peripheral holds request until granted; only pending requests get granted.
// [RL2] Seven channels in the first instance, five in the second.
// [RL3] A channel serves one active request at a time.
// [RL4] Each channel has a priority; an arbiter picks the next channel.
// [RL5] Directions per channel: peripheral-memory, memory-peripheral, memory-memory.
// [RL6] Every channel has its own hardware request input.
// [RL7] Software priority first, fixed hardware order breaks ties.
// [RL8] Per channel flags: half done, complete, error; each may interrupt.
// [RL9] Software can set each of the three flags.
// [RL10] Circular mode besides single-pass mode.
// [RL11] Item count programmable up to 65535.
// [RL12] Software enables only one peripheral request per shared channel.
// [RL13] Circular mode reloads count and both address pointers after last item.
// [RL14] Enabled pointers advance by the selected data width.
// [RL15] Peripheral and memory widths set independently; transfers adapt.
// [RL16] Equal priority goes to the lower channel number.
// [RL17] Four-bit source select routes one request to the channel.
module dmac_top
  import dmac_pkg::*;
#(
  parameter int NUM_CH = 7,
  parameter int FIFO_DEPTH = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic [31:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [31:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic [NUM_CH-1:0][N_SRC-1:0] periph_req,
  output logic [NUM_CH-1:0] periph_ack,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input logic [31:0] mem_rdata,
  input logic mem_ack,
  input logic mem_err,
  output logic [NUM_CH-1:0][FLG_N-1:0] event_irq
);
  // ==========================================================
  // Elaboration checks
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  if (NUM_CH < 1 || NUM_CH > 10) begin : g_chk // [RL2]
    $error("dmac_top: NUM_CH must be 1 to 10");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_CH-1:0][CFG_W-1:0] cfg;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt_base;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt_cur;
    logic [NUM_CH-1:0][31:0] pa_base;
    logic [NUM_CH-1:0][31:0] ma_base;
    logic [NUM_CH-1:0][31:0] pa_cur;
    logic [NUM_CH-1:0][31:0] ma_cur;
    logic [NUM_CH-1:0][FLG_N-1:0] flags;
    logic [NUM_CH-1:0] ack;
    dmac_xfer_e st;
    logic [CH_W-1:0] ch;
    logic mreq;
    logic mwe;
    logic [31:0] maddr;
    logic [1:0] memory_item_width;
    logic [31:0] mwdata;
    logic aw_held;
    logic w_held;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dmac_state_s;

  dmac_state_s s;
  dmac_state_s next_s;

  dmac_stream_if #(.W(32)) fq ();

  logic [NUM_CH-1:0] pending;
  logic [NUM_CH-1:0][PRI_W-1:0] prio;
  logic gnt_valid;
  logic [CH_W-1:0] gnt_idx;

  logic [NUM_CH-1:0][FLG_N-1:0] clr_f;
  logic [NUM_CH-1:0][FLG_N-1:0] set_f;
  logic [31:0] wmerged;
  logic [31:0] wrel;
  logic [31:0] rrel;
  logic [CH_W-1:0] wch;
  logic [CH_W-1:0] rch;
  logic whit;
  logic rhit;
  logic [CFG_W-1:0] ncfg;
  logic [CFG_W-1:0] gcfg;
  logic [CFG_W-1:0] ccfg;
  logic g_srcp;
  logic c_srcp;
  logic [CNT_W-1:0] left;

  // ==========================================================
  // Request selection and arbitration
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    // Only the selected source reaches the channel, so one request is live
    assign pending[i] = s.cfg[i][CFG_EN] // [RL1] [RL3]
      && s.cnt_cur[i] != '0
      && !s.ack[i]
      && (s.cfg[i][CFG_DIR +: 2] == DIR_M2M
          || periph_req[i][s.cfg[i][CFG_SEL +: SEL_W]]); // [RL6] [RL17] [RL12]
    assign prio[i] = s.cfg[i][CFG_PRI +: PRI_W]; // [RL4]
    assign event_irq[i] = s.flags[i] & s.cfg[i][CFG_ERR_IE:CFG_HALF_IE]; // [RL8]
  end

  dmac_arbiter #(
    .NUM_CH(NUM_CH),
    .CH_W(CH_W)
  ) u_arb (
    .pending(pending),
    .prio(prio),
    .grant_valid(gnt_valid),
    .grant_idx(gnt_idx)
  );

  dmac_fifo #(
    .W(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .q(fq.store)
  );

  // ==========================================================
  // Bus outputs
  assign awready = !s.aw_held;
  assign wready = !s.w_held;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign mem_req = s.mreq;
  assign mem_we = s.mwe;
  assign mem_addr = s.maddr;
  assign mem_size = s.memory_item_width;
  assign mem_wdata = s.mwdata;
  assign periph_ack = s.ack;

  // Read data is narrowed to the source width before it is buffered
  assign fq.in_valid = s.st == XF_READ && mem_ack && !mem_err;
  assign fq.in_data = mem_rdata & dmac_width_mask(s.memory_item_width); // [RL15]
  assign fq.out_ready = s.st == XF_WRITE && !s.mreq;

  // ==========================================================
  // Address decode
  assign wrel = s.awaddr - OFF_CH_BASE;
  assign rrel = araddr - OFF_CH_BASE;
  assign wch = CH_W'(wrel >> CH_SHIFT);
  assign rch = CH_W'(araddr >> CH_SHIFT);
  assign whit = s.awaddr[1:0] == 2'h0
    && (s.awaddr < OFF_CH_BASE || (wrel >> CH_SHIFT) < 32'(NUM_CH));
  assign rhit = araddr[1:0] == 2'h0
    && (araddr < OFF_CH_BASE || (rrel >> CH_SHIFT) < 32'(NUM_CH));
  assign gcfg = s.cfg[gnt_idx];
  assign ccfg = s.cfg[s.ch];
  assign g_srcp = gcfg[CFG_DIR +: 2] != DIR_M2P; // [RL5]
  assign c_srcp = ccfg[CFG_DIR +: 2] != DIR_M2P;

  always_comb begin
    next_s = s;
    next_s.ack = '0;
    clr_f = '0;
    set_f = '0;
    ncfg = '0;
    left = '0;
    for (int b = 0; b < 4; b++) begin
      wmerged[8*b +: 8] = s.wstrb[b] ? s.wdata[8*b +: 8] : 8'h00;
    end

    // ========================================================
    // Register write channel
    if (awvalid && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = whit ? RESP_OKAY : RESP_SLVERR;
      if (whit && s.awaddr == OFF_FLAG_CLR) begin
        clr_f = (NUM_CH*FLG_N)'(wmerged);
      end else if (whit && s.awaddr == OFF_SW_TRIG) begin
        set_f = (NUM_CH*FLG_N)'(wmerged); // [RL9]
      end else if (whit && s.awaddr >= OFF_CH_BASE) begin
        unique case (s.awaddr[CH_SHIFT-1:0])
          CH_CFG: begin
            ncfg = wmerged[CFG_W-1:0];
            next_s.cfg[wch] = ncfg;
            // Pointers and count restart when the channel is switched on
            if (ncfg[CFG_EN] && !s.cfg[wch][CFG_EN]) begin
              next_s.cnt_cur[wch] = s.cnt_base[wch];
              next_s.pa_cur[wch] = s.pa_base[wch];
              next_s.ma_cur[wch] = s.ma_base[wch];
            end
          end
          CH_CNT: begin
            // Count is locked while the channel runs
            if (!s.cfg[wch][CFG_EN]) begin
              next_s.cnt_base[wch] = wmerged[CNT_W-1:0]; // [RL11]
              next_s.cnt_cur[wch] = wmerged[CNT_W-1:0];
            end
          end
          CH_PADDR: begin
            next_s.pa_base[wch] = wmerged;
          end
          CH_MADDR: begin
            next_s.ma_base[wch] = wmerged;
          end
          default: begin
            next_s.bresp = RESP_SLVERR;
          end
        endcase
      end
    end

    // ========================================================
    // Register read channel
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end else if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata = 32'h0;
      if (rhit && araddr == OFF_FLAGS) begin
        next_s.rdata = 32'(s.flags);
      end else if (rhit && araddr >= OFF_CH_BASE) begin
        unique case (araddr[CH_SHIFT-1:0])
          CH_CFG: next_s.rdata = 32'(s.cfg[rch - 1'b1]);
          CH_CNT: next_s.rdata = 32'(s.cnt_cur[rch - 1'b1]);
          CH_PADDR: next_s.rdata = s.pa_base[rch - 1'b1];
          CH_MADDR: next_s.rdata = s.ma_base[rch - 1'b1];
          default: next_s.rresp = RESP_SLVERR;
        endcase
      end
    end

    // ========================================================
    // Transfer engine: one item read, buffered, then written
    unique case (s.st)
      XF_IDLE: begin
        if (gnt_valid && fq.in_ready) begin // [RL1] [RL4]
          next_s.ch = gnt_idx;
          next_s.st = XF_READ;
          next_s.mreq = 1'b1;
          next_s.mwe = 1'b0;
          next_s.maddr = g_srcp ? s.pa_cur[gnt_idx] : s.ma_cur[gnt_idx];
          next_s.memory_item_width = g_srcp ? gcfg[CFG_PW +: 2] : gcfg[CFG_MW +: 2]; // [RL15]
        end
      end
      XF_READ: begin
        if (mem_ack) begin
          next_s.mreq = 1'b0;
          next_s.st = mem_err ? XF_IDLE : XF_WRITE;
          if (mem_err) begin
            set_f[s.ch][FLG_ERR] = 1'b1; // [RL8]
            next_s.cfg[s.ch][CFG_EN] = 1'b0;
          end
        end
      end
      XF_WRITE: begin
        if (!s.mreq) begin
          if (fq.out_valid) begin
            next_s.mreq = 1'b1;
            next_s.mwe = 1'b1;
            next_s.maddr = c_srcp ? s.ma_cur[s.ch] : s.pa_cur[s.ch];
            next_s.memory_item_width = c_srcp ? ccfg[CFG_MW +: 2] : ccfg[CFG_PW +: 2];
            next_s.mwdata = fq.out_data & dmac_width_mask(next_s.memory_item_width); // [RL15]
          end
        end else if (mem_ack) begin
          next_s.mreq = 1'b0;
          next_s.st = XF_IDLE;
          if (mem_err) begin
            set_f[s.ch][FLG_ERR] = 1'b1; // [RL8]
            next_s.cfg[s.ch][CFG_EN] = 1'b0;
          end else begin
            next_s.ack[s.ch] = 1'b1; // [RL1]
            left = s.cnt_cur[s.ch] - 1'b1;
            next_s.cnt_cur[s.ch] = left;
            if (ccfg[CFG_PSTEP]) begin
              next_s.pa_cur[s.ch] = s.pa_cur[s.ch] + dmac_step(ccfg[CFG_PW +: 2]); // [RL14]
            end
            if (ccfg[CFG_MSTEP]) begin
              next_s.ma_cur[s.ch] = s.ma_cur[s.ch] + dmac_step(ccfg[CFG_MW +: 2]); // [RL14]
            end
            if (left == (s.cnt_base[s.ch] >> 1) && left != '0) begin
              set_f[s.ch][FLG_HALF] = 1'b1; // [RL8]
            end
            if (left == '0) begin
              set_f[s.ch][FLG_DONE] = 1'b1; // [RL8]
              if (ccfg[CFG_CIRC]) begin // [RL10]
                next_s.cnt_cur[s.ch] = s.cnt_base[s.ch]; // [RL13]
                next_s.pa_cur[s.ch] = s.pa_base[s.ch]; // [RL13]
                next_s.ma_cur[s.ch] = s.ma_base[s.ch]; // [RL13]
              end else begin
                next_s.cfg[s.ch][CFG_EN] = 1'b0;
              end
            end
          end
        end
      end
      default: begin
        next_s.st = XF_IDLE;
      end
    endcase

    // A set arriving with its clear wins
    next_s.flags = (s.flags & ~clr_f) | set_f; // [RL8] [RL9]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : dmac_top

// ### verification/dmac_top_sva.sv
`timescale 1ns/1ns
module dmac_top_sva
  import dmac_pkg::*;
#(
  parameter int NUM_CH = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [NUM_CH-1:0] periph_ack,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic mem_ack,
  input wire logic mem_err
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Steps of one item: read source, then write destination
  sequence s_rd_done;
    mem_req && mem_ack && !mem_we && !mem_err;
  endsequence
  sequence s_wr_start;
    !mem_req ##[1:2] (mem_req && mem_we);
  endsequence
  sequence s_wr_done;
    mem_req && mem_ack && mem_we && !mem_err;
  endsequence
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory access changed before its ack");
  a_read_write: assert property (
    s_rd_done |=> s_wr_start)
    else $error("write did not follow read");
  a_ack_item: assert property (
    s_wr_done |=> $onehot(periph_ack))
    else $error("no channel ack after write");
  a_ack_cause: assert property (
    periph_ack != '0 |-> $past(mem_ack && mem_we && !mem_err))
    else $error("channel ack without a write");
  a_one_active: assert property (
    $onehot0(periph_ack))
    else $error("several channels acked");
  a_req_drop: assert property (
    mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  a_size_legal: assert property (
    mem_req |-> mem_size != 2'h3)
    else $error("illegal item width");
  a_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) ##0 !arready)
    else $error("read data dropped");
endmodule : dmac_top_sva

bind dmac_top dmac_top_sva #(.NUM_CH(NUM_CH)) u_sva (.aclk, .aresetn, .bvalid, .bready,
  .bresp, .arready, .rvalid, .rready, .rdata, .periph_ack, .mem_req, .mem_we, .mem_addr,
  .mem_size, .mem_ack, .mem_err);

// ### verification/dmac_mem_model.sv
`timescale 1ns/1ns
module dmac_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  input wire logic [31:0] err_addr,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_err
);
  logic [31:0] wr_addr[$];
  logic [31:0] wr_data[$];
  int cnt;
  // ==========================================================
  // Answer after lat idle cycles; stale read data keeps toggling
  initial begin
    mem_ack = 1'b0;
    mem_err = 1'b0;
    mem_rdata = 32'h0;
    cnt = 0;
  end
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!aresetn || !mem_req || mem_ack) begin
      cnt <= 0;
    end else if (cnt < lat) begin
      cnt <= cnt + 1;
    end else begin
      mem_ack <= 1'b1;
      mem_err <= (mem_addr == err_addr);
      if (mem_we) begin
        wr_addr.push_back(mem_addr);
        wr_data.push_back(mem_wdata);
      end else begin
        mem_rdata <= {mem_addr[15:0], ~mem_addr[15:0]};
      end
    end
  end
endmodule : dmac_mem_model

// ### verification/dmac_tb_top.sv
`timescale 1ns/1ns
module dmac_tb_top;
  import dmac_pkg::*;
  localparam int NC = 7;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mem_req, mem_we, mem_ack, mem_err, slow;
  logic [31:0] awaddr, wdata, araddr, rdata, mem_addr, mem_wdata, mem_rdata, err_addr, d;
  logic [3:0] wstrb, lat;
  logic [1:0] bresp, rresp, mem_size, r;
  logic [NC-1:0][N_SRC-1:0] req;
  logic [NC-1:0] periph_ack;
  logic [NC-1:0][FLG_N-1:0] event_irq;
  int error_cnt, tests_run, n;
  dmac_top #(.NUM_CH(NC)) uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .periph_req(req), .periph_ack, .mem_req, .mem_we, .mem_addr,
    .mem_size, .mem_wdata, .mem_rdata, .mem_ack, .mem_err, .event_irq);
  dmac_mem_model mdl (.aclk, .aresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat,
    .err_addr, .mem_rdata, .mem_ack, .mem_err);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic tmo(inout int k);
    k++;
    if (k > 400) begin
      error_cnt++;
      conclude();
    end
  endtask : tmo
  // ==========================================================
  // Bus cycles; sampled at the falling edge, changed after the rising one
  // Slow mode raises ready only after valid, so the hold checks see a stalled answer
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic ta, tw, tb, tv;
    int k;
    tb = 1'b0;
    k = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      tv = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      else if (tv) bready <= 1'b1;
      tmo(k);
    end
    // Idle edge so the next call never reassigns bready in this step
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    logic ta, tr, tv;
    int k;
    tr = 1'b0;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      else if (tv) rready <= 1'b1;
      tmo(k);
    end
    @(posedge aclk);
  endtask : rd
  function automatic logic [31:0] cv(int dr, int c, int p, int s, int w);
    cv = 32'(15 | dr << CFG_DIR | c << CFG_CIRC | 3 << CFG_PSTEP | w << CFG_PW | w << CFG_MW
      | p << CFG_PRI | s << CFG_SEL);
  endfunction : cv
  task automatic setup(input int c, input logic [31:0] v, input logic [31:0] cn,
                       input logic [31:0] pa, input logic [31:0] ma);
    logic [31:0] b;
    b = OFF_CH_BASE + 32'(c << CH_SHIFT);
    wr(b + 32'(CH_CNT), cn);
    wr(b + 32'(CH_PADDR), pa);
    wr(b + 32'(CH_MADDR), ma);
    wr(b, v);
  endtask : setup
  task automatic wack(input int c, input int k);
    int t;
    t = 0;
    while (k > 0) begin
      @(negedge aclk);
      if (periph_ack[c] === 1'b1) k--;
      tmo(t);
    end
    @(posedge aclk);
  endtask : wack
  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    lat = 4'h0;
    req = '0;
    err_addr = 32'h300;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_FLAGS);
    chk(d, 32'h0);
    rd(OFF_CH_BASE + 32'h70);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(OFF_CH_BASE + 32'h70, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    for (int dr = 0; dr < 3; dr++) begin
      mdl.wr_addr.delete();
      mdl.wr_data.delete();
      lat <= 4'(dr * 3);
      setup(0, cv(dr, 0, 0, 3, 1), 32'h2, 32'h100, 32'h200);
      // Memory to memory starts without a request, so only the others can stall
      if (dr != 2) begin
        req[0][2] <= 1'b1;
        repeat (20) @(negedge aclk);
        chk(32'(mem_req), 32'h0);
        @(posedge aclk);
      end
      req[0][3] <= 1'b1;
      wack(0, 2);
      req[0] <= '0;
      chk(32'(mdl.wr_addr.size()), 32'h2);
      for (int i = 0; i < 2; i++) begin
        chk(mdl.wr_addr[i], (dr == 1 ? 32'h100 : 32'h200) + 32'(2 * i));
        d = (dr == 1 ? 32'h200 : 32'h100) + 32'(2 * i);
        chk(mdl.wr_data[i], {16'h0, ~d[15:0]});
      end
      @(negedge aclk);
      chk(32'(event_irq[0]), 32'h3);
      @(posedge aclk);
      rd(OFF_FLAGS);
      chk(d, 32'h3);
      rd(OFF_CH_BASE + 32'(CH_CNT));
      chk(d, 32'h0);
      wr(OFF_FLAG_CLR, 32'h7);
      wr(OFF_CH_BASE, 32'h0);
    end
    lat <= 4'h0;
    for (int k = 0; k < 2; k++) begin
      mdl.wr_addr.delete();
      setup(1, cv(0, 0, 1, 0, 2), 32'h1, 32'h110, 32'h1000);
      setup(2, cv(0, 0, 1 + k, 0, 2), 32'h1, 32'h120, 32'h2000);
      req[1][0] <= 1'b1;
      req[2][0] <= 1'b1;
      wack(k == 0 ? 2 : 1, 1);
      req <= '0;
      chk(mdl.wr_addr[0], k == 0 ? 32'h1000 : 32'h2000);
      wr(OFF_CH_BASE + 32'h10, 32'h0);
      wr(OFF_CH_BASE + 32'h20, 32'h0);
    end
    mdl.wr_addr.delete();
    setup(3, cv(0, 1, 0, 0, 2), 32'h1, 32'h130, 32'h3000);
    req[3][0] <= 1'b1;
    wack(3, 2);
    wr(OFF_CH_BASE + 32'h30, 32'h0);
    req <= '0;
    chk(mdl.wr_addr[1], 32'h3000);
    setup(5, cv(0, 0, 0, 0, 2), 32'h1, 32'h300, 32'h400);
    req[5][0] <= 1'b1;
    n = 0;
    while (event_irq[5][2] !== 1'b1) begin
      @(negedge aclk);
      tmo(n);
    end
    @(posedge aclk);
    req <= '0;
    rd(OFF_CH_BASE + 32'h50);
    chk(32'(d[0]), 32'h0);
    wr(OFF_FLAG_CLR, 32'hFFFFFFFF);
    wr(OFF_CH_BASE + 32'h40, 32'hE);
    slow = 1'b1;
    // Software set must work with the channel idle
    for (int k = 0; k < 3; k++) begin
      wr(OFF_SW_TRIG, 32'h1000 << k);
      rd(OFF_FLAGS);
      chk(d, (32'h2000 << k) - 32'h1000);
    end
    @(negedge aclk);
    chk(32'(event_irq[4]), 32'h7);
    @(posedge aclk);
    wr(OFF_FLAGS, 32'hFFFFFFFF);
    // Byte lane 0 alone cannot reach bits 14:12
    wstrb <= 4'h1;
    wr(OFF_FLAG_CLR, 32'h7000);
    wstrb <= 4'hF;
    rd(OFF_FLAGS);
    chk(d, 32'h7000);
    wr(OFF_FLAG_CLR, 32'h7000);
    rd(OFF_FLAGS);
    chk(d, 32'h0);
    conclude();
  end
endmodule : dmac_tb_top
